// ==== design/timebase_pkg.sv ====
// Constants and types for the counter array time base control block
package timebase_pkg;

   localparam logic [7:0] ADDR_CONTROL = 8'hD8;
   localparam logic [7:0] ADDR_MODE = 8'hD9;
   localparam logic [7:0] ADDR_COUNT_LO = 8'hE9;
   localparam logic [7:0] ADDR_COUNT_HI = 8'hF9;

   localparam int NUM_MODULES = 5;
   localparam int SYNC_STAGES = 2;

   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] COUNT_BYTE_RESET = 8'h00;
   localparam logic [7:0] CONTROL_READ_MASK = 8'hDF;
   localparam logic [7:0] MODE_READ_MASK = 8'hC7;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [7:0] HALF_RATE_LIMIT = 8'h01;
   localparam logic [7:0] NO_DIVIDE_LIMIT = 8'h00;

   typedef enum logic [1:0] {
      SRC_PRESCALED = 2'b00,
      SRC_HALF = 2'b01,
      SRC_TIMER0 = 2'b10,
      SRC_EXTERNAL = 2'b11
   } count_src_t;

   typedef struct packed {
      logic idle_halt;
      logic module4_watchdog_enable;
      logic [2:0] unused;
      logic count_source_sel_hi;
      logic count_source_sel_lo;
      logic overflow_irq_enable;
   } mode_t;

   typedef struct packed {
      logic overflow_flag;
      logic counter_run;
      logic unused;
      logic [4:0] module_event_flag;
   } control_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic bit_wr;
      logic [2:0] bit_sel;
      logic bit_val;
   } sfr_req_t;

endpackage

// ==== design/edge_strobe.sv ====
// Two-flop synchroniser with a one-cycle falling or rising edge strobe
`timescale 1ns/1ns
`default_nettype none
module edge_strobe
   import timebase_pkg::*;
#(
   parameter int STAGES = SYNC_STAGES,
   parameter bit FALLING = 1'b1
) (
   input wire logic clk,     // Peripheral clock
   input wire logic rst_n,   // Asynchronous reset, active low
   input wire logic din,     // Unsynchronised level
   output logic strobe       // One pulse per selected edge
);

   logic [STAGES-1:0] sync_reg;
   logic prev_reg;
   logic strobe_reg;
   wire logic synced = sync_reg[STAGES-1];
   wire logic edge_seen = FALLING ? (prev_reg & ~synced)
                                  : (~prev_reg & synced);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_reg <= '0;
         prev_reg <= 1'b0;
         strobe_reg <= 1'b0;
      end else begin
         sync_reg <= {sync_reg[STAGES-2:0], din};
         prev_reg <= synced;
         strobe_reg <= edge_seen;
      end
   end

   assign strobe = strobe_reg;

endmodule
`default_nettype wire

// ==== design/tick_divider.sv ====
// Free-running divider giving one tick every limit+1 clock cycles
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
   parameter int WIDTH = 8
) (
   input wire logic clk,               // Peripheral clock
   input wire logic rst_n,             // Asynchronous reset, active low
   input wire logic [WIDTH-1:0] limit, // Divide ratio minus one
   output logic tick                   // One-cycle tick
);

   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   logic tick_reg;
   wire logic at_limit = (count_reg >= limit);

   assign count_next = at_limit ? '0 : count_reg + 1'b1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick_reg <= at_limit;
      end
   end

   assign tick = tick_reg;

endmodule
`default_nettype wire

// ==== design/counter_array_timebase_control.sv ====
// Time base, control and mode registers and request of the counter array
`timescale 1ns/1ns
`default_nettype none
module counter_array_timebase_control
   import timebase_pkg::*;
#(
   parameter int PRESCALE_WIDTH = 8
) (
   input wire logic MCLK,                       // Peripheral clock
   input wire logic RESETN,                     // Async reset, active low
   input wire sfr_req_t SFR_REQ,                // Register access request
   output logic [7:0] SFR_RDATA,                // Read data, one cycle late
   input wire logic IDLE_MODE,                  // Processor in idle
   input wire logic FAST_MODE,                  // Fast timing mode
   input wire logic ARRAY_DOUBLE_SPEED,         // Clock control 0 bit
   input wire logic [PRESCALE_WIDTH-1:0] PRESCALE_VALUE, // Prescale
   input wire logic TIMER0_OVERFLOW,            // Timer 0 overflow pulse
   input wire logic EXTERNAL_COUNT_INPUT,       // External count pin
   input wire logic ARRAY_IRQ_ENABLE,           // Enable in irq reg 0
   input wire logic [NUM_MODULES-1:0] MODULE_EVENT, // Match/capture
   input wire logic [NUM_MODULES-1:0] MODULE_EVENT_IRQ_ENABLE, // Enables
   output logic [15:0] COUNT,                   // Shared time base
   output logic MODULE4_WATCHDOG_ENABLE,        // Module 4 watchdog on
   output logic ARRAY_IRQ                       // Combined request
);

   ////////////////////////////////////////////////////////////////////////
   // Register decode

   function automatic logic [7:0] merge_write(input logic [7:0] old,
                                              input sfr_req_t req);
      logic [7:0] result;
      result = old;
      if (req.wr) begin
         result = req.wdata;
      end else if (req.bit_wr) begin
         result[req.bit_sel] = req.bit_val;
      end
      return result;
   endfunction

   control_t control_reg;
   control_t control_next;
   mode_t mode_reg;
   mode_t mode_next;
   logic [7:0] count_lo_reg;
   logic [7:0] count_hi_reg;
   logic [15:0] count_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic irq_reg;
   logic irq_next;

   wire logic sel_control = (SFR_REQ.addr == ADDR_CONTROL);
   wire logic sel_mode = (SFR_REQ.addr == ADDR_MODE);
   wire logic sel_lo = (SFR_REQ.addr == ADDR_COUNT_LO);
   wire logic sel_hi = (SFR_REQ.addr == ADDR_COUNT_HI);

   // Only the control register takes single-bit writes
   wire logic wr_control = sel_control & (SFR_REQ.wr | SFR_REQ.bit_wr);
   wire logic wr_mode = sel_mode & SFR_REQ.wr;
   wire logic wr_lo = sel_lo & SFR_REQ.wr;
   wire logic wr_hi = sel_hi & SFR_REQ.wr;
   wire logic wr_count = wr_lo | wr_hi;

   wire logic [7:0] control_written = merge_write(control_reg, SFR_REQ);
   wire control_t sw_control = control_t'(control_written);

   ////////////////////////////////////////////////////////////////////////
   // Count source selection

   wire logic [15:0] count_now = {count_hi_reg, count_lo_reg};
   wire count_src_t source = count_src_t'({mode_reg.count_source_sel_hi,
                                           mode_reg.count_source_sel_lo});
   wire logic prescale_on = ~FAST_MODE | ARRAY_DOUBLE_SPEED;
   wire logic [PRESCALE_WIDTH-1:0] prescale_limit =
      prescale_on ? PRESCALE_VALUE
                  : PRESCALE_WIDTH'(NO_DIVIDE_LIMIT);

   logic tick_prescaled;
   logic tick_half;
   logic tick_timer0;
   logic tick_external;

   tick_divider #(
      .WIDTH(PRESCALE_WIDTH)
   ) u_prescale_div (
      .clk(MCLK),
      .rst_n(RESETN),
      .limit(prescale_limit),
      .tick(tick_prescaled)
   );

   tick_divider #(
      .WIDTH(8)
   ) u_half_div (
      .clk(MCLK),
      .rst_n(RESETN),
      .limit(HALF_RATE_LIMIT),
      .tick(tick_half)
   );

   edge_strobe #(
      .STAGES(SYNC_STAGES),
      .FALLING(1'b0)
   ) u_timer0_edge (
      .clk(MCLK),
      .rst_n(RESETN),
      .din(TIMER0_OVERFLOW),
      .strobe(tick_timer0)
   );

   edge_strobe #(
      .STAGES(SYNC_STAGES),
      .FALLING(1'b1)
   ) u_external_edge (
      .clk(MCLK),
      .rst_n(RESETN),
      .din(EXTERNAL_COUNT_INPUT),
      .strobe(tick_external)
   );

   logic source_tick;
   always_comb begin
      case (source)
         SRC_PRESCALED: source_tick = tick_prescaled;
         SRC_HALF: source_tick = tick_half;
         SRC_TIMER0: source_tick = tick_timer0;
         SRC_EXTERNAL: source_tick = tick_external;
         default: source_tick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter

   wire logic idle_stop = mode_reg.idle_halt & IDLE_MODE;
   wire logic count_en = control_reg.counter_run & ~idle_stop
                         & source_tick & ~wr_count;
   wire logic wrap = count_en & (count_now == COUNT_MAX);

   always_comb begin
      count_next = count_now;
      if (count_en) begin
         count_next = count_now + 16'h0001;
      end
      if (wr_lo) begin
         count_next[7:0] = SFR_REQ.wdata;
      end
      if (wr_hi) begin
         count_next[15:8] = SFR_REQ.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control, mode and flags

   always_comb begin
      control_next = control_reg;
      if (wr_control) begin
         control_next = sw_control;
      end
      control_next.unused = 1'b0;
      // Hardware set is applied last so it wins a same-cycle clear
      control_next.overflow_flag = control_next.overflow_flag | wrap;
      control_next.module_event_flag = control_next.module_event_flag
                                       | MODULE_EVENT;
   end

   always_comb begin
      mode_next = mode_reg;
      if (wr_mode) begin
         mode_next = mode_t'(SFR_REQ.wdata);
      end
      mode_next.unused = 3'b000;
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt request

   wire logic ovf_request = control_reg.overflow_flag
                            & mode_reg.overflow_irq_enable;
   wire logic [NUM_MODULES-1:0] module_request =
      control_reg.module_event_flag & MODULE_EVENT_IRQ_ENABLE;

   assign irq_next = ARRAY_IRQ_ENABLE
                     & (ovf_request | (|module_request));

   ////////////////////////////////////////////////////////////////////////
   // Read path

   always_comb begin
      rdata_next = rdata_reg;
      if (SFR_REQ.rd) begin
         if (sel_control) begin
            rdata_next = control_reg & CONTROL_READ_MASK;
         end else if (sel_mode) begin
            rdata_next = mode_reg & MODE_READ_MASK;
         end else if (sel_lo) begin
            rdata_next = count_lo_reg;
         end else if (sel_hi) begin
            rdata_next = count_hi_reg;
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         control_reg <= control_t'(CONTROL_RESET);
         mode_reg <= mode_t'(MODE_RESET);
         count_lo_reg <= COUNT_BYTE_RESET;
         count_hi_reg <= COUNT_BYTE_RESET;
      end else begin
         control_reg <= control_next;
         mode_reg <= mode_next;
         count_lo_reg <= count_next[7:0];
         count_hi_reg <= count_next[15:8];
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_reg <= 8'h00;
         irq_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign SFR_RDATA = rdata_reg;
   assign COUNT = count_now;
   assign MODULE4_WATCHDOG_ENABLE = mode_reg.module4_watchdog_enable;
   assign ARRAY_IRQ = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   sequence wrap_cycle;
      control_reg.counter_run && !idle_stop && source_tick && !wr_count
         && count_now == 16'hFFFF;
   endsequence

   sequence wrapped_state;
      count_now == 16'h0000 && control_reg.overflow_flag;
   endsequence

   chk_idle_halt_freeze: assert property (
      (mode_reg.idle_halt && IDLE_MODE && !wr_count) |=> $stable(COUNT))
      else $error("counter moved while halted in idle");

   chk_watchdog_follows: assert property (
      wr_mode |=> MODULE4_WATCHDOG_ENABLE == $past(SFR_REQ.wdata[6]))
      else $error("watchdog enable does not follow mode write");

   chk_half_rate_gap: assert property (
      (count_en && source == SRC_HALF && !wr_mode)
         |=> !count_en)
      else $error("half rate source counted on adjacent cycles");

   chk_undivided_fast: assert property (
      (FAST_MODE && !ARRAY_DOUBLE_SPEED) [*3] |-> prescale_limit == '0)
      else $error("prescale applied in fast mode without double speed");

   chk_ovf_irq_mask: assert property (
      (!mode_reg.overflow_irq_enable && module_request == '0)
         |=> !ARRAY_IRQ)
      else $error("masked overflow raised a request");

   chk_run_stop: assert property (
      (!control_reg.counter_run && !wr_count) |=> $stable(COUNT))
      else $error("counter moved with run bit clear");

   chk_wrap_sets_ovf: assert property (
      wrap_cycle |=> wrapped_state)
      else $error("wrap did not set overflow flag");

   chk_ovf_irq_raise: assert property (
      (control_reg.overflow_flag && mode_reg.overflow_irq_enable
         && ARRAY_IRQ_ENABLE) |=> ARRAY_IRQ)
      else $error("enabled overflow flag did not request");

   chk_ovf_sticky: assert property (
      (control_reg.overflow_flag && !wr_control)
         |=> control_reg.overflow_flag)
      else $error("overflow flag cleared without software");

   chk_event_sets: assert property (
      (MODULE_EVENT != '0) |=> ((control_reg.module_event_flag
         & $past(MODULE_EVENT)) == $past(MODULE_EVENT)))
      else $error("module event did not set its flag");

   chk_event_sticky: assert property (
      !wr_control |=> ((control_reg.module_event_flag
         & $past(control_reg.module_event_flag))
         == $past(control_reg.module_event_flag)))
      else $error("module flag cleared without software");

   chk_array_gate: assert property (
      !ARRAY_IRQ_ENABLE |=> !ARRAY_IRQ)
      else $error("request raised with array enable clear");

   chk_control_reserved: assert property (
      (SFR_REQ.rd && sel_control) |=> SFR_RDATA[5] == 1'b0)
      else $error("control bit 5 read as one");

   chk_mode_reserved: assert property (
      (SFR_REQ.rd && sel_mode) |=> SFR_RDATA[5:3] == 3'b000)
      else $error("mode reserved bits read as one");

   chk_module_irq_one_line: assert property (
      (ARRAY_IRQ_ENABLE && module_request != '0) |=> ARRAY_IRQ)
      else $error("module request missing on shared line");

   chk_low_byte_write: assert property (
      wr_lo |=> COUNT[7:0] == $past(SFR_REQ.wdata))
      else $error("low count byte not written");

   chk_set_beats_clear: assert property (
      (wr_control && !sw_control.overflow_flag && wrap)
         |=> control_reg.overflow_flag)
      else $error("same-cycle clear lost an overflow");

   chk_external_single: assert property (
      tick_external |=> !tick_external)
      else $error("external edge counted twice");

endmodule
`default_nettype wire

// ==== verification/test_counter_array_timebase_control.sv ====
// Self-checking bench for the counter array time base control block
`timescale 1ns/1ns
`default_nettype none
module test_counter_array_timebase_control
   import timebase_pkg::*;
   ;
   logic mclk, resetn, idle_mode, fast_mode, dbl_speed, t0_ovf, ext_in;
   logic arr_ie, wdog, irq;
   logic [7:0] prescale, rdata, d;
   logic [4:0] mod_ev, mod_ie, ev, ie;
   logic [15:0] count, c0, dl, v;
   sfr_req_t req;
   int n_errors, check_count, cycles, p, m, n, flags_m;

   counter_array_timebase_control dut_u (
      .MCLK(mclk), .RESETN(resetn), .SFR_REQ(req), .SFR_RDATA(rdata),
      .IDLE_MODE(idle_mode), .FAST_MODE(fast_mode),
      .ARRAY_DOUBLE_SPEED(dbl_speed), .PRESCALE_VALUE(prescale),
      .TIMER0_OVERFLOW(t0_ovf), .EXTERNAL_COUNT_INPUT(ext_in),
      .ARRAY_IRQ_ENABLE(arr_ie), .MODULE_EVENT(mod_ev),
      .MODULE_EVENT_IRQ_ENABLE(mod_ie), .COUNT(count),
      .MODULE4_WATCHDOG_ENABLE(wdog), .ARRAY_IRQ(irq)
   );

   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end

   function automatic sfr_req_t mk(logic [7:0] a, logic [7:0] dt, logic w,
                                   logic r, logic b, logic [2:0] s, logic bv);
      return '{a, dt, w, r, b, s, bv};
   endfunction

   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One request held for exactly one edge, with optional module events
   task automatic bus(input sfr_req_t q, input logic [4:0] evs);
      @(posedge mclk);
      req <= q;
      mod_ev <= evs;
      @(posedge mclk);
      req <= mk(q.addr, 8'h00, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0);
      mod_ev <= 5'h00;
      // Let the registers written on this edge settle before callers look
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] dt);
      bus(mk(a, dt, 1'h1, 1'h0, 1'h0, 3'h0, 1'h0), 5'h00);
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chkrd(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
      bus(mk(a, 8'h00, 1'h0, 1'h1, 1'h0, 3'h0, 1'h0), 5'h00);
      #1 d = rdata;
      chk(nm, {8'h00, e}, {8'h00, d});
   endtask

   // Count advance over m clock edges
   task automatic delta(input int mm, output logic [15:0] dd);
      @(posedge mclk);
      #1 c0 = count;
      repeat (mm) @(posedge mclk);
      #1 dd = count - c0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'h0;
      idle_mode = 1'h0;
      fast_mode = 1'h0;
      dbl_speed = 1'h0;
      t0_ovf = 1'h0;
      ext_in = 1'h1;
      arr_ie = 1'h0;
      prescale = 8'h00;
      mod_ev = 5'h00;
      mod_ie = 5'h00;
      req = mk(8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0);
      void'($urandom(9));
      repeat (8) @(posedge mclk);
      resetn <= 1'h1;
      chkrd("control reset", ADDR_CONTROL, 8'h00);
      chkrd("mode reset", ADDR_MODE, 8'h00);
      chkrd("count lo reset", ADDR_COUNT_LO, 8'h00);
      chkrd("count hi reset", ADDR_COUNT_HI, 8'h00);
      chk("irq reset", 16'h0000, {15'h0000, irq});
      // Mode reserved bits and watchdog output
      wr(ADDR_MODE, 8'hFF);
      chkrd("mode readback", ADDR_MODE, 8'hC7);
      chkrd("unmapped read", 8'h55, 8'h00);
      chk("watchdog on", 16'h0001, {15'h0000, wdog});
      wr(ADDR_MODE, 8'h00);
      chk("watchdog off", 16'h0000, {15'h0000, wdog});
      wr(8'h55, 8'hFF);
      bus(mk(ADDR_MODE, 8'h00, 1'h0, 1'h0, 1'h1, 3'h0, 1'h1), 5'h00);
      bus(mk(ADDR_CONTROL, 8'h00, 1'h0, 1'h0, 1'h1, 3'h5, 1'h1), 5'h00);
      chkrd("mode no bit access", ADDR_MODE, 8'h00);
      chkrd("control bit5", ADDR_CONTROL, 8'h00);
      // Counter bytes, stopped counter
      v = 16'($urandom);
      wr(ADDR_COUNT_LO, v[7:0]);
      wr(ADDR_COUNT_HI, v[15:8]);
      chk("count value", v, count);
      chkrd("count lo", ADDR_COUNT_LO, v[7:0]);
      chkrd("count hi", ADDR_COUNT_HI, v[15:8]);
      delta(50, dl);
      chk("stopped count", 16'h0000, dl);
      // Prescaled source in compatibility, fast, and fast double speed
      wr(ADDR_CONTROL, 8'h40);
      for (int k = 0; k < 3; k++) begin
         p = $urandom_range(7);
         @(posedge mclk);
         prescale <= 8'(p);
         fast_mode <= (k > 0);
         dbl_speed <= (k == 2);
         repeat (300) @(posedge mclk);
         m = (p + 1) * 8;
         delta(m, dl);
         chk("prescaled rate", (k == 1) ? 16'(m) : 16'h0008, dl);
      end
      // Half rate, then idle with and without halt
      wr(ADDR_MODE, 8'h02);
      repeat (4) @(posedge mclk);
      delta(20, dl);
      chk("half rate", 16'h000A, dl);
      @(posedge mclk);
      idle_mode <= 1'h1;
      delta(20, dl);
      chk("idle running", 16'h000A, dl);
      wr(ADDR_MODE, 8'h82);
      delta(20, dl);
      chk("idle halted", 16'h0000, dl);
      @(posedge mclk);
      idle_mode <= 1'h0;
      // Timer 0 overflow and external input edges
      for (int s = 2; s < 4; s++) begin
         wr(ADDR_MODE, 8'(s << 1));
         n = $urandom_range(1, 8);
         @(posedge mclk);
         #1 c0 = count;
         repeat (n) begin
            @(posedge mclk);
            if (s == 2) t0_ovf <= 1'h1;
            else ext_in <= 1'h0;
            repeat (3) @(posedge mclk);
            if (s == 2) t0_ovf <= 1'h0;
            else ext_in <= 1'h1;
            repeat (2) @(posedge mclk);
         end
         repeat (6) @(posedge mclk);
         #1 chk("edge count", 16'(n), count - c0);
      end
      // Overflow flag and its request, every enable combination
      @(posedge mclk);
      fast_mode <= 1'h1;
      dbl_speed <= 1'h0;
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CONTROL, 8'h00);
         wr(ADDR_MODE, 8'(k & 1));
         @(posedge mclk);
         arr_ie <= k[1];
         wr(ADDR_COUNT_LO, 8'hFE);
         wr(ADDR_COUNT_HI, 8'hFF);
         wr(ADDR_CONTROL, 8'h40);
         // Rewrite lands on the wrap edge; the flag must still set
         wr(ADDR_CONTROL, 8'h40);
         chkrd("overflow set", ADDR_CONTROL, 8'hC0);
         chk("overflow irq", 16'(k == 3), {15'h0000, irq});
         repeat (300) @(posedge mclk);
         chkrd("overflow held", ADDR_CONTROL, 8'hC0);
         bus(mk(ADDR_CONTROL, 8'h00, 1'h0, 1'h0, 1'h1, 3'h7, 1'h0), 5'h00);
         chkrd("overflow cleared", ADDR_CONTROL, 8'h40);
         chk("irq after clear", 16'h0000, {15'h0000, irq});
      end
      // Module event flags and their requests
      wr(ADDR_CONTROL, 8'h00);
      flags_m = 0;
      for (int i = 0; i < 8; i++) begin
         ev = 5'($urandom);
         ie = 5'($urandom);
         @(posedge mclk);
         mod_ie <= ie;
         arr_ie <= 1'($urandom);
         bus(mk(ADDR_CONTROL, 8'h00, 1'h0, 1'h0, 1'h0, 3'h0, 1'h0), ev);
         flags_m = flags_m | ev;
         chkrd("event flags", ADDR_CONTROL, 8'(flags_m));
         chk("event irq", 16'(arr_ie & |(5'(flags_m) & ie)),
             {15'h0000, irq});
      end
      // Hardware set wins over a clear in the same cycle
      for (int b = 0; b < 5; b++) begin
         bus(mk(ADDR_CONTROL, 8'h00, 1'h0, 1'h0, 1'h1, 3'(b), 1'h0),
             5'h01 << b);
      end
      chkrd("set beats clear", ADDR_CONTROL, 8'h1F);
      for (int b = 0; b < 5; b++) begin
         bus(mk(ADDR_CONTROL, 8'h00, 1'h0, 1'h0, 1'h1, 3'(b), 1'h0), 5'h00);
      end
      chkrd("flags cleared", ADDR_CONTROL, 8'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
